// ==== shared/olf_pkg.sv ====
// Constants for the overlay layer frame configuration bank.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz clock.
package olf_pkg;

  // ==========================================================
  // Register map: word indices, byte address is four times
  localparam int IDX_W = 9;
  localparam int LAYERS = 2;
  localparam int LAYER_SLOTS = 12;
  localparam int REG_NUM = 25;
  localparam int SLOT_CURSOR = 24;

  // Slot order inside each layer block
  localparam int S_MODE = 0;
  localparam int S_EXT = 1;
  localparam int S_OA0 = 2;
  localparam int S_DA0 = 3;
  localparam int S_OA1 = 4;
  localparam int S_DA1 = 5;
  localparam int S_SCRX = 6;
  localparam int S_SCRY = 7;
  localparam int S_WINX = 8;
  localparam int S_WINY = 9;
  localparam int S_WINW = 10;
  localparam int S_WINH = 11;

  // Word index of each slot (layer 4, layer 5, cursor)
  localparam logic [IDX_W-1:0] REG_IDX [REG_NUM] = '{
    9'h070, 9'h150, 9'h074, 9'h078, 9'h07C, 9'h080,
    9'h084, 9'h086, 9'h154, 9'h156, 9'h158, 9'h15A,
    9'h088, 9'h160, 9'h08C, 9'h090, 9'h094, 9'h098,
    9'h09C, 9'h09E, 9'h164, 9'h166, 9'h168, 9'h16A,
    9'h0A0};

  // Writable bits of each slot; all others read zero
  localparam logic [31:0] M_MODE = 32'hE0FF0FFF;
  localparam logic [31:0] M_OA = 32'h03FFFFF0;
  localparam logic [31:0] M_DA = 32'h03FFFFFF;
  localparam logic [31:0] M_POS = 32'h00000FFF;
  localparam logic [31:0] REG_MASK [REG_NUM] = '{
    M_MODE, 32'hC0F00003, M_OA, M_DA, M_OA, M_DA,
    M_POS, M_POS, M_POS, M_POS, M_POS, M_POS,
    M_MODE, 32'hC0000003, M_OA, M_DA, M_OA, M_DA,
    M_POS, M_POS, M_POS, M_POS, M_POS, M_POS,
    32'h000001FF};
  localparam logic [31:0] REG_RESET = 32'h00000000;

  // ==========================================================
  // Field positions
  localparam int HEIGHT_LSB = 0;
  localparam int STRIDE_LSB = 16;
  localparam int FLIP_LSB = 29;
  localparam int COLOR_BIT = 31;
  localparam int WP_BIT = 0;
  localparam int OM_BIT = 1;
  localparam int EC_LSB = 30;
  localparam int CUR_CODE_LSB = 0;
  localparam int CUR_ZERO_BIT = 8;
  localparam int STRIDE_SHIFT = 6;

  // ==========================================================
  // Encodings
  localparam logic [1:0] FLIP_FRAME0 = 2'h0;
  localparam logic [1:0] FLIP_FRAME1 = 2'h1;
  localparam logic [1:0] FLIP_ALT = 2'h2;
  localparam logic [1:0] EXTC_BASIC = 2'h0;
  localparam logic [1:0] EXTC_DIRECT24 = 2'h1;
  localparam logic [1:0] COLOR_INDIRECT8 = 2'h0;
  localparam logic [1:0] COLOR_DIRECT16 = 2'h1;
  localparam logic [1:0] COLOR_DIRECT24 = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    ST_IDLE, ST_WRITE, ST_READ, ST_READ_OUT
  } olf_bus_state_t;

endpackage

// ==== rtl/olf_ahb_slave.sv ====
// AHB-Lite slave front end for the layer configuration bank.
// Assumes single word transfers; reads take one wait state.
`timescale 1ns/1ps
`default_nettype none
module olf_ahb_slave (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic regWr,
  output logic [olf_pkg::IDX_W-1:0] regIdx,
  output logic [31:0] regWdata,
  input wire logic [31:0] regRdata
);
  olf_pkg::olf_bus_state_t state_r;
  olf_pkg::olf_bus_state_t state_nxt;
  logic [olf_pkg::IDX_W-1:0] idx_r;
  logic ok_r;
  logic [31:0] rdata_r;

  wire addrPhase = hsel & htrans[1] & hready;
  wire addrOk = (haddr[31:11] == 21'h000000) && (haddr[1:0] == 2'h0)
                && (hsize == olf_pkg::HSIZE_WORD);

  always_comb begin
    case (state_r)
      olf_pkg::ST_READ: state_nxt = olf_pkg::ST_READ_OUT;
      default: begin
        if (addrPhase) begin
          state_nxt = hwrite ? olf_pkg::ST_WRITE : olf_pkg::ST_READ;
        end else begin
          state_nxt = olf_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= olf_pkg::ST_IDLE;
      idx_r <= '0;
      ok_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      if (addrPhase) begin
        idx_r <= haddr[10:2];
        ok_r <= addrOk;
      end
      if (state_r == olf_pkg::ST_READ) begin
        rdata_r <= ok_r ? regRdata : 32'h00000000;
      end
    end
  end

  // Unmapped or odd-sized accesses read zero and write nothing
  assign hreadyout = (state_r != olf_pkg::ST_READ);
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign regWr = (state_r == olf_pkg::ST_WRITE) && ok_r;
  assign regIdx = idx_r;
  assign regWdata = hwdata;
endmodule
`default_nettype wire

// ==== rtl/olf_layer_sel.sv ====
// Per-layer frame selection and mode decode for one overlay layer.
// Assumes frameStart pulses once per displayed frame.
`timescale 1ns/1ps
`default_nettype none
module olf_layer_sel (
  input wire logic clk,
  input wire logic reset,
  input wire logic frameStart,
  input wire logic [31:0] modeReg,
  input wire logic [31:0] extReg,
  input wire logic [31:0] origin0,
  input wire logic [31:0] display0,
  input wire logic [31:0] origin1,
  input wire logic [31:0] display1,
  output logic [31:0] originAddr,
  output logic [31:0] displayAddr,
  output logic showFrame1,
  output logic [1:0] colorMode,
  output logic [12:0] frameHeight,
  output logic [13:0] strideBytes,
  output logic windowEnable,
  output logic overlayExt
);
  logic alt_r;
  logic [1:0] flip;
  logic [1:0] extColor;
  logic useFrame1;
  logic [1:0] colorSel;
  logic [31:0] dispSel;

  assign flip = modeReg[olf_pkg::FLIP_LSB +: 2];
  assign extColor = extReg[olf_pkg::EC_LSB +: 2];
  assign useFrame1 = (flip == olf_pkg::FLIP_FRAME1)
                     || ((flip == olf_pkg::FLIP_ALT) && alt_r);
  assign colorSel = (extColor == olf_pkg::EXTC_DIRECT24)
                    ? olf_pkg::COLOR_DIRECT24
                    : (modeReg[olf_pkg::COLOR_BIT]
                       ? olf_pkg::COLOR_DIRECT16
                       : olf_pkg::COLOR_INDIRECT8);
  assign dispSel = useFrame1 ? display1 : display0;

  always_ff @(posedge clk) begin
    if (reset) begin
      alt_r <= 1'b0;
      originAddr <= 32'h00000000;
      displayAddr <= 32'h00000000;
      showFrame1 <= 1'b0;
      colorMode <= olf_pkg::COLOR_INDIRECT8;
      frameHeight <= 13'h0000;
      strideBytes <= 14'h0000;
      windowEnable <= 1'b0;
      overlayExt <= 1'b0;
    end else begin
      if (frameStart) begin
        alt_r <= (flip == olf_pkg::FLIP_ALT) ? ~alt_r : 1'b0;
      end
      originAddr <= (useFrame1 ? origin1 : origin0)
                    & olf_pkg::M_OA;
      displayAddr <= {dispSel[31:1],
        dispSel[0] & (colorSel != olf_pkg::COLOR_DIRECT16)};
      showFrame1 <= useFrame1;
      colorMode <= colorSel;
      frameHeight <= {1'b0, modeReg[olf_pkg::HEIGHT_LSB +: 12]} + 13'h0001;
      strideBytes <= {modeReg[olf_pkg::STRIDE_LSB +: 8], 6'h00};
      windowEnable <= extReg[olf_pkg::WP_BIT];
      overlayExt <= extReg[olf_pkg::OM_BIT];
    end
  end
endmodule
`default_nettype wire

// ==== rtl/olf_regs.sv ====
// Register bank for overlay layers 4 and 5 plus cursor transparency.
// Assumes an AHB-Lite master and a display pipeline that reads the
// decoded per-layer outputs; index 0 of each layer array is layer 4.
`timescale 1ns/1ps
`default_nettype none
module olf_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic frameStart,
  input wire logic cursorValid,
  input wire logic [7:0] cursorCode,
  output logic cursorTransparent,
  output logic [1:0][31:0] layerOriginAddr,
  output logic [1:0][31:0] layerDisplayAddr,
  output logic [1:0] layerShowFrame1,
  output logic [1:0][1:0] layerColorMode,
  output logic [1:0][12:0] layerFrameHeight,
  output logic [1:0][13:0] layerStrideBytes,
  output logic [1:0] layerWindowEnable,
  output logic [1:0] layerOverlayExt,
  output logic [1:0][11:0] layerScrollX,
  output logic [1:0][11:0] layerScrollY,
  output logic [1:0][11:0] layerWindowX,
  output logic [1:0][11:0] layerWindowY,
  output logic [1:0][11:0] layerWindowWidth,
  output logic [1:0][12:0] layerWindowHeight
);

  // ==========================================================
  // Bus front end
  logic regWr;
  logic [olf_pkg::IDX_W-1:0] regIdx;
  logic [31:0] regWdata;
  logic [31:0] regRdata;

  olf_ahb_slave olf_ahb_slave_inst (
    .clk(clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .regWr(regWr),
    .regIdx(regIdx),
    .regWdata(regWdata),
    .regRdata(regRdata)
  );

  // ==========================================================
  // Register storage, one entry per slot
  logic [31:0] regVal [olf_pkg::REG_NUM];
  logic [31:0] rdTerm [olf_pkg::REG_NUM];

  for (genvar g = 0; g < olf_pkg::REG_NUM; g++) begin : g_reg
    logic [31:0] val_r;
    wire hit = (regIdx == olf_pkg::REG_IDX[g]);
    always_ff @(posedge clk) begin
      if (reset) begin
        val_r <= olf_pkg::REG_RESET;
      end else if (regWr && hit) begin
        val_r <= regWdata & olf_pkg::REG_MASK[g];
      end
    end
    assign regVal[g] = val_r;
    assign rdTerm[g] = hit ? (val_r & olf_pkg::REG_MASK[g]) : 32'h00000000;
  end

  // Unmapped indices hit no slot and read zero
  always_comb begin
    regRdata = 32'h00000000;
    for (int i = 0; i < olf_pkg::REG_NUM; i++) begin
      regRdata = regRdata | rdTerm[i];
    end
  end

  // ==========================================================
  // Per-layer decode for the display pipeline
  for (genvar l = 0; l < olf_pkg::LAYERS; l++) begin : g_layer
    localparam int B = l * olf_pkg::LAYER_SLOTS;

    olf_layer_sel olf_layer_sel_inst (
      .clk(clk),
      .reset(reset),
      .frameStart(frameStart),
      .modeReg(regVal[B + olf_pkg::S_MODE]),
      .extReg(regVal[B + olf_pkg::S_EXT]),
      .origin0(regVal[B + olf_pkg::S_OA0]),
      .display0(regVal[B + olf_pkg::S_DA0]),
      .origin1(regVal[B + olf_pkg::S_OA1]),
      .display1(regVal[B + olf_pkg::S_DA1]),
      .originAddr(layerOriginAddr[l]),
      .displayAddr(layerDisplayAddr[l]),
      .showFrame1(layerShowFrame1[l]),
      .colorMode(layerColorMode[l]),
      .frameHeight(layerFrameHeight[l]),
      .strideBytes(layerStrideBytes[l]),
      .windowEnable(layerWindowEnable[l]),
      .overlayExt(layerOverlayExt[l])
    );

    always_ff @(posedge clk) begin
      if (reset) begin
        layerScrollX[l] <= 12'h000;
        layerScrollY[l] <= 12'h000;
        layerWindowX[l] <= 12'h000;
        layerWindowY[l] <= 12'h000;
        layerWindowWidth[l] <= 12'h000;
        layerWindowHeight[l] <= 13'h0000;
      end else begin
        layerScrollX[l] <= regVal[B + olf_pkg::S_SCRX][11:0];
        layerScrollY[l] <= regVal[B + olf_pkg::S_SCRY][11:0];
        layerWindowX[l] <= regVal[B + olf_pkg::S_WINX][11:0];
        layerWindowY[l] <= regVal[B + olf_pkg::S_WINY][11:0];
        layerWindowWidth[l] <= regVal[B + olf_pkg::S_WINW][11:0];
        layerWindowHeight[l] <=
          {1'b0, regVal[B + olf_pkg::S_WINH][11:0]} + 13'h0001;
      end
    end
  end

  // ==========================================================
  // Cursor transparency test
  logic [7:0] transCode;
  logic zeroTransparent;
  logic cursorHit;

  assign transCode = regVal[olf_pkg::SLOT_CURSOR][olf_pkg::CUR_CODE_LSB +: 8];
  assign zeroTransparent = regVal[olf_pkg::SLOT_CURSOR][olf_pkg::CUR_ZERO_BIT];
  // code zero follows its own bit
  assign cursorHit = (cursorCode == 8'h00) ? zeroTransparent
                                           : (cursorCode == transCode);

  always_ff @(posedge clk) begin
    if (reset) begin
      cursorTransparent <= 1'b0;
    end else begin
      cursorTransparent <= cursorValid && cursorHit;
    end
  end

endmodule
`default_nettype wire

// ==== test/olf_regs_checker.sv ====
// Port assertions for the overlay layer configuration bank.
// Assumes one clock, synchronous active-high reset, hready=hreadyout.
`timescale 1ns/1ps
`default_nettype none
module olf_regs_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic frameStart,
  input wire logic cursorValid,
  input wire logic cursorTransparent,
  input wire logic [1:0][31:0] layerOriginAddr,
  input wire logic [1:0][31:0] layerDisplayAddr,
  input wire logic [1:0] layerShowFrame1,
  input wire logic [1:0][1:0] layerColorMode,
  input wire logic [1:0][12:0] layerFrameHeight,
  input wire logic [1:0][13:0] layerStrideBytes,
  input wire logic [1:0][12:0] layerWindowHeight
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic takeRd;
  logic takeWr;
  assign takeRd = hsel && htrans[1] && hready && !hwrite;
  assign takeWr = hsel && htrans[1] && hready && hwrite;

  // ==========================================================
  // Bus timing
  read_wait_a: assert property (takeRd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (takeWr |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");

  // ==========================================================
  // Decoded fields
  origin_align_a: assert property (
    layerOriginAddr[0][3:0] == 4'h0 && layerOriginAddr[1][3:0] == 4'h0)
    else $error("origin address not aligned");
  disp_align_a: assert property (
    !(layerColorMode[0] == olf_pkg::COLOR_DIRECT16
    && layerDisplayAddr[0][0]) && !(layerDisplayAddr[1][0]
    && layerColorMode[1] == olf_pkg::COLOR_DIRECT16))
    else $error("display address odd in 16 bpp");
  height_plus_a: assert property (
    !$past(reset) |-> layerWindowHeight[0] != 13'h0
    && layerWindowHeight[1] != 13'h0 && layerFrameHeight[0] != 13'h0
    && layerFrameHeight[1] != 13'h0)
    else $error("height below one");
  stride_unit_a: assert property (
    layerStrideBytes[0][5:0] == 6'h0 && layerStrideBytes[1][5:0] == 6'h0)
    else $error("stride not in 64 byte units");
  color_code_a: assert property (
    layerColorMode[0] != 2'h3 && layerColorMode[1] != 2'h3)
    else $error("color mode code 3");
  flip_cause_a: assert property (
    $changed(layerShowFrame1) |-> $past(frameStart)
    || $past(frameStart, 2) || $past(takeWr, 2) || $past(takeWr, 3))
    else $error("frame select changed without cause");
  cursor_cause_a: assert property (
    cursorTransparent |-> $past(cursorValid))
    else $error("transparent without valid pixel");
endmodule
`default_nettype wire

// ==== test/olf_regs_tb.sv ====
// Self-checking bench for the overlay layer configuration bank.
// Assumes olf_pkg and olf_regs compiled first; checker bound below.
`timescale 1ns/1ps
`default_nettype none
module olf_regs_tb;
  logic clk, reset, hsel, hwrite, frameStart, cursorValid;
  logic hreadyout, hresp, cursorTransparent;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans, show, wen, oext;
  logic [2:0] hsize;
  logic [7:0] cursorCode;
  logic [1:0][31:0] org, dsp;
  logic [1:0][1:0] cmode;
  logic [1:0][12:0] fh, wh;
  logic [1:0][13:0] sb;
  logic [1:0][11:0] scx, scy, wx, wy, ww;
  logic [31:0] vals [12] = '{32'hBFA5F123, 32'h3, 32'h100, 32'h201,
    32'h30F, 32'h401, 32'h11, 32'h22, 32'h33, 32'h44, 32'h55, 32'h66};
  logic [7:0] codes [6] = '{8'hA5, 8'h00, 8'h5A, 8'hA5, 8'h00, 8'hA5};
  logic [5:0] valids = 6'h37;
  logic [5:0] transp = 6'h23;
  int fails = 0;
  int comparisons = 0;

  olf_regs olf_regs_inst (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .frameStart(frameStart),
    .cursorValid(cursorValid), .cursorCode(cursorCode),
    .cursorTransparent(cursorTransparent), .layerOriginAddr(org),
    .layerDisplayAddr(dsp), .layerShowFrame1(show),
    .layerColorMode(cmode), .layerFrameHeight(fh),
    .layerStrideBytes(sb), .layerWindowEnable(wen),
    .layerOverlayExt(oext), .layerScrollX(scx), .layerScrollY(scy),
    .layerWindowX(wx), .layerWindowY(wy), .layerWindowWidth(ww),
    .layerWindowHeight(wh));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One single AHB-Lite transfer; read data lands in rdv
  task automatic xfer(input logic wr, input logic [31:0] a,
      input logic [31:0] wd);
    @(posedge clk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  function automatic logic [31:0] ba(input int s);
    return {21'h0, olf_pkg::REG_IDX[s], 2'h0};
  endfunction

  task automatic wr(input int s, input logic [31:0] d);
    xfer(1'b1, ba(s), d);
  endtask

  task automatic rdchk(input int s, input logic [31:0] e);
    xfer(1'b0, ba(s), 32'h0);
    check("register", rdv, e);
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // ==========================================================
  // Test sequence
  initial begin
    int b;
    reset = 1'b1;
    hsel = 1'b1;
    hsize = olf_pkg::HSIZE_WORD;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    frameStart = 1'b0;
    cursorValid = 1'b0;
    cursorCode = 8'h00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int s = 0; s < olf_pkg::REG_NUM; s++) begin
      rdchk(s, olf_pkg::REG_RESET);
      wr(s, 32'hFFFFFFFF);
      rdchk(s, olf_pkg::REG_MASK[s]);
      wr(s, (s == olf_pkg::S_WINW ||
        s == olf_pkg::LAYER_SLOTS + olf_pkg::S_WINW) ? 32'h1 : 32'h0);
    end
    settle();
    check("height", {fh[1], fh[0]}, 32'h02001);
    check("winh", {wh[1], wh[0]}, 32'h02001);
    check("winw", {ww[1], ww[0]}, 32'h001001);
    xfer(1'b1, 32'h800001C0, 32'hFFFFFFFF);
    rdchk(0, 32'h0);
    xfer(1'b1, 32'h00000004, 32'hFFFFFFFF);
    xfer(1'b0, 32'h00000004, 32'h0);
    check("unmapped", rdv, 32'h0);
    hsize <= 3'h0;
    wr(0, 32'hFFFFFFFF);
    hsize <= olf_pkg::HSIZE_WORD;
    rdchk(0, 32'h0);
    for (int l = 0; l < 2; l++) begin
      b = l * olf_pkg::LAYER_SLOTS;
      for (int s = 0; s < 12; s++) begin
        wr(b + s, vals[s]);
      end
      rdchk(b, 32'hA0A50123);
      settle();
      check("height", fh[l], 32'h124);
      check("stride", sb[l], 32'h2940);
      check("frame1", show[l], 32'h1);
      check("color", cmode[l], 32'h1);
      check("origin", org[l], 32'h300);
      check("display", dsp[l], 32'h400);
      check("winen", wen[l], 32'h1);
      check("ovext", oext[l], 32'h1);
      check("scroll", {scy[l], scx[l]}, 32'h022011);
      check("winpos", {wy[l], wx[l]}, 32'h044033);
      check("winw", ww[l], 32'h55);
      check("winh", wh[l], 32'h67);
      wr(b, 32'h00A50123);
      settle();
      check("display", dsp[l], 32'h201);
      check("origin", org[l], 32'h100);
      check("color", cmode[l], 32'h0);
      wr(b + 1, 32'h40000000);
      settle();
      check("color", cmode[l], {30'h0, olf_pkg::COLOR_DIRECT24});
      check("modes", {wen[l], oext[l]}, 32'h0);
      wr(b, 32'h40A50123);
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        frameStart <= 1'b1;
        @(posedge clk);
        frameStart <= 1'b0;
        settle();
        check("flip", dsp[l], k[0] ? 32'h201 : 32'h401);
      end
      wr(b, 32'h60A50123);
      settle();
      check("flip11", show[l], 32'h0);
      check("display", dsp[l], 32'h201);
      wr(b + 1, 32'h80000000);
      settle();
      check("color", cmode[l], 32'h0);
    end
    wr(olf_pkg::SLOT_CURSOR, 32'h000001A5);
    for (int k = 0; k < 6; k++) begin
      if (k == 4) begin
        wr(olf_pkg::SLOT_CURSOR, 32'h000000A5);
      end
      @(posedge clk);
      cursorValid <= valids[k];
      cursorCode <= codes[k];
      settle();
      check("cursor", cursorTransparent, transp[k]);
    end
    report_and_stop();
  end
endmodule

bind olf_regs olf_regs_checker olf_regs_checker_inst (.clk(clk),
  .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .frameStart(frameStart), .cursorValid(cursorValid),
  .cursorTransparent(cursorTransparent),
  .layerOriginAddr(layerOriginAddr), .layerDisplayAddr(layerDisplayAddr),
  .layerShowFrame1(layerShowFrame1), .layerColorMode(layerColorMode),
  .layerFrameHeight(layerFrameHeight),
  .layerStrideBytes(layerStrideBytes),
  .layerWindowHeight(layerWindowHeight));
`default_nettype wire
